// File: oversampler_pkg.sv
// Shared constants for the converter oversampler and status block.
// Assumes a single 125 MHz clock and a 32-bit Avalon-MM register slave.
package oversampler_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_OVS_CONTROL = 4'h8;
  localparam logic [3:0] ADDR_RESULT = 4'hC;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_WDOG_FLAG = 0;
  localparam int BIT_EOC_FLAG = 1;
  localparam int BIT_START_FLAG = 4;
  localparam int BIT_EOC_IRQ_EN = 5;
  localparam int BIT_WDOG_IRQ_EN = 6;
  localparam int BIT_OVS_ENABLE = 0;
  localparam int POS_OVS_RATIO = 2;
  localparam int POS_OVS_SHIFT = 5;
  localparam int BIT_CONV_ON = 9;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int SAMPLE_W = 12;
  localparam int ACC_W = 20;
  localparam int RESULT_W = 16;
  localparam int RATIO_W = 3;
  localparam int SHIFT_W = 4;
  localparam int COUNT_W = 9;
  localparam logic [3:0] SHIFT_MAX = 4'h8;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] OVS_CONTROL_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_t;

endpackage

// File: ovs_datapath_if.sv
// Carries one sample into the oversampling datapath and its word back out.
// Both ends run on the one system clock.
`timescale 1ns/1ps
interface ovs_datapath_if;
  import oversampler_pkg::*;
  logic sample_valid;
  logic [SAMPLE_W-1:0] sample;
  logic enable;
  logic [RATIO_W-1:0] ratio;
  logic [SHIFT_W-1:0] shift;
  logic restart;
  logic word_valid;
  logic [RESULT_W-1:0] word;
  modport ctrl (output sample_valid, output sample, output enable, output ratio, output shift,
    output restart, input word_valid, input word);
  modport dp (input sample_valid, input sample, input enable, input ratio, input shift,
    input restart, output word_valid, output word);
endinterface

// File: ovs_accumulator.sv
// Sum-then-shift-then-round oversampling datapath.
// Assumes settings are held stable while conversions run.
`timescale 1ns/1ps
module ovs_accumulator (
  input wire logic i_clk,
  input wire logic i_srst,
  ovs_datapath_if.dp dpif
);
  import oversampler_pkg::*;

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [COUNT_W-1:0] count;
    logic word_valid;
    logic [RESULT_W-1:0] word;
  } acc_state_t;

  acc_state_t st_reg;
  acc_state_t st_next;
  logic [COUNT_W-1:0] target;
  logic [ACC_W-1:0] total;
  logic [ACC_W-1:0] shifted;
  logic [ACC_W-1:0] rounded;
  logic round_bit;
  logic [SHIFT_W-1:0] sh;

  // Ratio code k gives N = 2^(k+1), so 2 to 256
  assign target = COUNT_W'(2) << dpif.ratio;

  always_comb begin
    st_next = st_reg;
    st_next.word_valid = 1'b0;
    total = st_reg.acc + ACC_W'(dpif.sample);
    // Shifts above eight are clamped: the field only defines 0..8
    sh = (dpif.shift > SHIFT_MAX) ? SHIFT_MAX : dpif.shift;
    shifted = total >> sh;
    // Rounding must use the last bit dropped by the clamped shift
    round_bit = (sh == 4'h0) ? 1'b0 : total[sh - 4'h1];
    rounded = shifted + ACC_W'(round_bit);
    if (dpif.restart) begin
      st_next.acc = '0;
      st_next.count = '0;
    end else if (dpif.sample_valid) begin
      if (!dpif.enable) begin
        st_next.word = RESULT_W'(dpif.sample);
        st_next.word_valid = 1'b1;
      end else if (st_reg.count + COUNT_W'(1) == target) begin
        st_next.word = rounded[RESULT_W-1:0];
        st_next.word_valid = 1'b1;
        st_next.acc = '0;
        st_next.count = '0;
      end else begin
        st_next.acc = total;
        st_next.count = st_reg.count + COUNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dpif.word_valid = st_reg.word_valid;
  assign dpif.word = st_reg.word;
endmodule

// File: adc_oversampler_and_status.sv
// Oversampler, status flags and interrupt of a successive-approximation converter.
// Assumes the converter core pulses its events synchronously to I_CLK_SYS.
`timescale 1ns/1ps

module adc_oversampler_and_status (
  input wire logic I_CLK_SYS,
  input wire logic I_SRST,
  input wire logic [oversampler_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [oversampler_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic i_seq_start,
  input wire logic i_conv_valid,
  input wire logic [oversampler_pkg::SAMPLE_W-1:0] i_conv_data,
  input wire logic i_seq_end,
  input wire logic i_wdog_event,
  output logic [oversampler_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_result_valid,
  output logic o_irq
);
  import oversampler_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    bus_state_t bus;
    logic [DATA_W-1:0] rdata;
    logic start_flag;
    logic eoc_flag;
    logic wdog_flag;
    logic eoc_irq_en;
    logic wdog_irq_en;
    logic ovs_enable;
    logic [RATIO_W-1:0] ovs_ratio;
    logic [SHIFT_W-1:0] ovs_shift;
    logic conv_on;
    logic [RESULT_W-1:0] result;
    logic result_valid;
    logic eoc_pending;
    logic irq;
  } top_state_t;

  top_state_t st_reg;
  top_state_t st_next;
  ovs_datapath_if dpif ();
  logic access;
  logic wr_hit;
  logic rd_hit;
  logic full_word;
  logic clr_start;
  logic clr_eoc;
  logic clr_wdog;
  logic [DATA_W-1:0] rd_word;

  // ****************************************
  // Datapath
  // ****************************************
  // Samples feed straight through: no added wait states on the conversion path
  assign dpif.sample_valid = i_conv_valid;
  assign dpif.sample = i_conv_data;
  assign dpif.enable = st_reg.ovs_enable;
  assign dpif.ratio = st_reg.ovs_ratio;
  assign dpif.shift = st_reg.ovs_shift;
  // While conv_on is low any partial sum is cleared, so counting restarts from zero when it is set
  assign dpif.restart = !st_reg.conv_on;

  ovs_accumulator u_acc (
    .i_clk(I_CLK_SYS),
    .i_srst(I_SRST),
    .dpif(dpif)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  assign access = st_reg.bus == BUS_ANSWER;
  assign wr_hit = access && i_avs_write;
  assign rd_hit = access && i_avs_read;
  // Partial writes to status are ignored so a stray byte cannot clear flags
  assign full_word = i_avs_byteenable == 4'hF;
  assign clr_start = wr_hit && full_word && i_avs_address == ADDR_STATUS
    && !i_avs_writedata[BIT_START_FLAG];
  assign clr_eoc = (wr_hit && full_word && i_avs_address == ADDR_STATUS
    && !i_avs_writedata[BIT_EOC_FLAG]) || (rd_hit && i_avs_address == ADDR_RESULT);
  assign clr_wdog = wr_hit && full_word && i_avs_address == ADDR_STATUS
    && !i_avs_writedata[BIT_WDOG_FLAG];

  always_comb begin
    rd_word = '0;
    unique case (i_avs_address)
      ADDR_STATUS: begin
        rd_word[BIT_START_FLAG] = st_reg.start_flag;
        rd_word[BIT_EOC_FLAG] = st_reg.eoc_flag;
        rd_word[BIT_WDOG_FLAG] = st_reg.wdog_flag;
      end
      ADDR_CONTROL: begin
        rd_word[BIT_EOC_IRQ_EN] = st_reg.eoc_irq_en;
        rd_word[BIT_WDOG_IRQ_EN] = st_reg.wdog_irq_en;
      end
      ADDR_OVS_CONTROL: begin
        rd_word[BIT_OVS_ENABLE] = st_reg.ovs_enable;
        rd_word[POS_OVS_RATIO +: RATIO_W] = st_reg.ovs_ratio;
        rd_word[POS_OVS_SHIFT +: SHIFT_W] = st_reg.ovs_shift;
        rd_word[BIT_CONV_ON] = st_reg.conv_on;
      end
      ADDR_RESULT: begin
        rd_word[RESULT_W-1:0] = st_reg.result;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.result_valid = 1'b0;
    // One wait cycle per access: request seen, then answered
    unique case (st_reg.bus)
      BUS_IDLE: begin
        if (i_avs_read || i_avs_write) begin
          st_next.bus = BUS_ANSWER;
          st_next.rdata = rd_word;
        end
      end
      BUS_ANSWER: begin
        st_next.bus = BUS_IDLE;
      end
      default: begin
        st_next.bus = BUS_IDLE;
      end
    endcase

    if (wr_hit && i_avs_address == ADDR_CONTROL) begin
      if (i_avs_byteenable[0]) begin
        st_next.eoc_irq_en = i_avs_writedata[BIT_EOC_IRQ_EN];
        st_next.wdog_irq_en = i_avs_writedata[BIT_WDOG_IRQ_EN];
      end
    end
    if (wr_hit && i_avs_address == ADDR_OVS_CONTROL && full_word) begin
      st_next.conv_on = i_avs_writedata[BIT_CONV_ON];
      // Settings are frozen while converting, so a running sum stays coherent
      if (!st_reg.conv_on) begin
        st_next.ovs_enable = i_avs_writedata[BIT_OVS_ENABLE];
        st_next.ovs_ratio = i_avs_writedata[POS_OVS_RATIO +: RATIO_W];
        st_next.ovs_shift = i_avs_writedata[POS_OVS_SHIFT +: SHIFT_W];
      end
    end

    if (dpif.word_valid) begin
      st_next.result = dpif.word;
      st_next.result_valid = 1'b1;
    end
    // With ovs_enable set, end of sequence is held until its word lands, then flags it; with it clear, it flags at once
    if (i_seq_end) begin
      st_next.eoc_pending = 1'b1;
    end else if (dpif.word_valid || !st_reg.ovs_enable) begin
      st_next.eoc_pending = 1'b0;
    end

    // Set wins over clear on every flag
    if (clr_start) begin
      st_next.start_flag = 1'b0;
    end
    if (i_seq_start) begin
      st_next.start_flag = 1'b1;
    end
    if (clr_eoc) begin
      st_next.eoc_flag = 1'b0;
    end
    if ((i_seq_end && !st_reg.ovs_enable) || (st_reg.eoc_pending && dpif.word_valid)
        || (i_seq_end && dpif.word_valid)) begin
      st_next.eoc_flag = 1'b1;
    end
    if (clr_wdog) begin
      st_next.wdog_flag = 1'b0;
    end
    if (i_wdog_event) begin
      st_next.wdog_flag = 1'b1;
    end

    st_next.irq = (st_next.eoc_flag && st_next.eoc_irq_en)
      || (st_next.wdog_flag && st_next.wdog_irq_en);
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_avs_readdata = st_reg.rdata;
  assign o_avs_waitrequest = !access;
  assign o_result_valid = st_reg.result_valid;
  assign o_irq = st_reg.irq;
endmodule

// File: adc_oversampler_and_status_props.sv
// Bus, result and interrupt checks on the top-level ports.
// Assumes it is bound to the block with every pin connected by name.
`timescale 1ns/1ps
module adc_oversampler_and_status_props (
  input wire logic I_CLK_SYS,
  input wire logic I_SRST,
  input wire logic [oversampler_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic i_conv_valid,
  input wire logic i_seq_end,
  input wire logic i_wdog_event,
  input wire logic [oversampler_pkg::DATA_W-1:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_result_valid,
  input wire logic o_irq
);
  import oversampler_pkg::*;
  logic ev;
  // Any cause that may legally raise the interrupt
  assign ev = i_seq_end | i_wdog_event | i_conv_valid | (i_avs_write & ~o_avs_waitrequest);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SRST);
  // ****************************************
  // Register bus
  // ****************************************
  sequence taken_s;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence answer_s;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  bus_cycle_a: assert property (taken_s |=> answer_s) else $error("bus answer late");
  idle_hold_a: assert property (!(i_avs_read || i_avs_write) && o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("answer without request");
  unmapped_zero_a: assert property (taken_s and i_avs_read && i_avs_address[1:0] != 2'h0 |=> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (o_avs_waitrequest && $past(o_avs_waitrequest) |-> $stable(o_avs_readdata))
    else $error("read data moved while idle");
  // ****************************************
  // Result and interrupt
  // ****************************************
  reset_quiet_a: assert property (disable iff (1'b0) I_SRST |=> o_avs_waitrequest && !o_irq && !o_result_valid)
    else $error("outputs active after reset");
  word_timing_a: assert property (o_result_valid |-> $past(i_conv_valid, 2)) else $error("word without sample");
  irq_fall_a: assert property ($fell(o_irq) |-> $past(I_SRST) || !$past(o_avs_waitrequest)
    || !$past(o_avs_waitrequest, 2) || !$past(o_avs_waitrequest, 3)) else $error("irq dropped by itself");
  irq_rise_a: assert property ($rose(o_irq) |-> $past(ev) || $past(ev, 2) || $past(ev, 3) || $past(ev, 4))
    else $error("irq raised without cause");
endmodule

// File: converter_core_model.sv
// Behavioural converter core: results and sequence events.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
module converter_core_model #(parameter int GAP = 2) (
  input wire logic i_clk,
  output logic o_seq_start,
  output logic o_conv_valid,
  output logic [11:0] o_conv_data,
  output logic o_seq_end,
  output logic o_wdog_event
);
  initial {o_seq_start, o_conv_valid, o_conv_data, o_seq_end, o_wdog_event} = 16'h0;
  // Equal spacing for every conversion of a sequence
  task conv(input logic [11:0] d);
    @(posedge i_clk);
    o_conv_valid <= 1'b1;
    o_conv_data <= d;
    @(posedge i_clk);
    o_conv_valid <= 1'b0;
    o_conv_data <= ~d; // Data is not held past the strobe
    repeat (GAP) @(posedge i_clk);
  endtask
  task evt(input int w);
    @(posedge i_clk);
    o_seq_start <= (w == 0);
    o_seq_end <= (w == 1);
    o_wdog_event <= (w == 2);
    @(posedge i_clk);
    {o_seq_start, o_seq_end, o_wdog_event} <= 3'h0;
  endtask
endmodule

// File: test_adc_oversampler_and_status.sv
// Self-checking bench for the oversampler and status block.
// Assumes the core model and the checker are compiled first.
`timescale 1ns/1ps
module test_adc_oversampler_and_status;
  import oversampler_pkg::*;
  logic I_CLK_SYS = 1'b0;
  logic I_SRST = 1'b1;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic st, cv, se, wd, waitreq, rv, irq;
  logic [11:0] cd;
  logic [31:0] rdata;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int npulse = 0;
  integer seed = 65;
  adc_oversampler_and_status dut (.I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .i_seq_start(st), .i_conv_valid(cv), .i_conv_data(cd), .i_seq_end(se), .i_wdog_event(wd),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .o_result_valid(rv), .o_irq(irq));
  converter_core_model core (.i_clk(I_CLK_SYS), .o_seq_start(st), .o_conv_valid(cv),
    .o_conv_data(cd), .o_seq_end(se), .o_wdog_event(wd));
  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  initial forever #4 I_CLK_SYS = ~I_CLK_SYS;
  always @(posedge I_CLK_SYS) begin
    cycles <= cycles + 1;
    if (rv === 1'b1) npulse = npulse + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      stop_test();
    end
  end
  task stop_test;
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] v);
    compares++;
    if (v !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, v);
    end
  endtask
  // Rounded shift of the sum, low 16 bits kept
  function automatic logic [15:0] ovs(input logic [19:0] sum, input int s);
    logic [19:0] t;
    t = sum >> s;
    if (s > 0) t = t + 20'(sum[s-1]);
    return t[15:0];
  endfunction
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b, output logic [31:0] q);
    @(posedge I_CLK_SYS);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= b;
    @(posedge I_CLK_SYS);
    while (waitreq !== 1'b0) @(posedge I_CLK_SYS);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task wreg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask
  task rchk(input logic [3:0] a, input logic [31:0] e, input string n);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(n, e, q);
  endtask
  task settle;
    repeat (3) @(negedge I_CLK_SYS);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] cfg, q;
    logic [19:0] sum;
    logic [11:0] d;
    int s;
    repeat (6) @(posedge I_CLK_SYS);
    I_SRST <= 1'b0;
    rchk(ADDR_STATUS, 32'h0, "status reset");
    rchk(ADDR_CONTROL, 32'h0, "control reset");
    rchk(ADDR_OVS_CONTROL, 32'h0, "ovs reset");
    rchk(4'h2, 32'h0, "unmapped");
    wreg(ADDR_OVS_CONTROL, 32'h200);
    d = 12'($random(seed));
    core.conv(d);
    rchk(ADDR_RESULT, {20'h0, d}, "passthrough");
    // Every ratio; shift 12 checks the clamp, full-scale 256x checks truncation
    for (int k = 0; k < 8; k++) begin
      s = (k == 7) ? 0 : (k == 6) ? 12 : $unsigned($random(seed)) % 9;
      cfg = 32'h1 | 32'(k << 2) | 32'(s << 5);
      wreg(ADDR_OVS_CONTROL, cfg);
      wreg(ADDR_OVS_CONTROL, cfg | 32'h200);
      wreg(ADDR_OVS_CONTROL, 32'h200);
      rchk(ADDR_OVS_CONTROL, cfg | 32'h200, "locked config");
      sum = 20'h0;
      npulse = 0;
      for (int i = 0; i < (2 << k); i++) begin
        d = (k == 7) ? 12'hFFF : 12'($random(seed));
        sum = sum + 20'(d);
        core.conv(d);
      end
      s = (s > 8) ? 8 : s;
      rchk(ADDR_RESULT, {16'h0, ovs(sum, s)}, "ovs word");
      chk("words", 32'h1, npulse);
      wreg(ADDR_OVS_CONTROL, 32'h0);
    end
    wreg(ADDR_OVS_CONTROL, 32'h200);
    for (int w = 0; w < 3; w++) core.evt(w);
    rchk(ADDR_STATUS, 32'h13, "flags set");
    bus(1'b1, ADDR_STATUS, 32'h0, 4'h3, q);
    rchk(ADDR_STATUS, 32'h13, "half write");
    wreg(ADDR_STATUS, 32'h12);
    rchk(ADDR_STATUS, 32'h12, "wdog clear");
    rchk(ADDR_RESULT, 32'hFF00, "result hold");
    rchk(ADDR_STATUS, 32'h10, "read clear");
    wreg(ADDR_STATUS, 32'h0);
    rchk(ADDR_STATUS, 32'h0, "start clear");
    wreg(ADDR_CONTROL, 32'h20);
    core.evt(1);
    settle();
    chk("irq eoc", 32'h1, irq);
    wreg(ADDR_CONTROL, 32'h40);
    settle();
    chk("irq masked", 32'h0, irq);
    core.evt(2);
    settle();
    chk("irq wdog", 32'h1, irq);
    wreg(ADDR_STATUS, 32'h0);
    settle();
    chk("irq clear", 32'h0, irq);
    stop_test();
  end
endmodule
bind adc_oversampler_and_status adc_oversampler_and_status_props u_props (.I_CLK_SYS(I_CLK_SYS),
  .I_SRST(I_SRST), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_conv_valid(i_conv_valid), .i_seq_end(i_seq_end), .i_wdog_event(i_wdog_event),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_result_valid(o_result_valid), .o_irq(o_irq));
